// [hw/pdr_pkg.sv]
// Purpose: Constants for the byte-wide port data and direction register block.
// Assumes: 16-bit byte-access internal I/O bus, 8 pins per port.
// Notes: Eight ports, numbered by slot 0..7 for ports 1,2,3,5,6,7,8,9.
package pdr_pkg;
	localparam int unsigned PORT_COUNT = 8;
	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned ADDR_WIDTH = 16;
	localparam int unsigned SLOT_WIDTH = 3;
	localparam logic [15:0] PORT1_PIN_DATA_ADDR = 16'hFFD4;
	localparam logic [15:0] PORT2_PIN_DATA_ADDR = 16'hFFD5;
	localparam logic [15:0] PORT3_PIN_DATA_ADDR = 16'hFFD6;
	localparam logic [15:0] PORT5_PIN_DATA_ADDR = 16'hFFD8;
	localparam logic [15:0] PORT6_PIN_DATA_ADDR = 16'hFFD9;
	localparam logic [15:0] PORT7_PIN_DATA_ADDR = 16'hFFDA;
	localparam logic [15:0] PORT8_PIN_DATA_ADDR = 16'hFFDB;
	localparam logic [15:0] PORT9_PIN_DATA_ADDR = 16'hFFDC;
	localparam logic [15:0] PORT1_DIRECTION_ADDR = 16'hFFE4;
	localparam logic [15:0] PORT2_DIRECTION_ADDR = 16'hFFE5;
	localparam logic [15:0] PORT3_DIRECTION_ADDR = 16'hFFE6;
	localparam logic [15:0] PORT5_DIRECTION_ADDR = 16'hFFE8;
	localparam logic [15:0] PORT6_DIRECTION_ADDR = 16'hFFE9;
	localparam logic [15:0] PORT7_DIRECTION_ADDR = 16'hFFEA;
	localparam logic [15:0] PORT8_DIRECTION_ADDR = 16'hFFEB;
	localparam logic [15:0] PORT9_DIRECTION_ADDR = 16'hFFEC;
	localparam logic [7:0] DIRECTION_READ_VALUE = 8'hFF;
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'hFF;
	typedef enum logic [1:0] {
		PDR_HIT_NONE = 2'h1,
		PDR_HIT_DATA = 2'h2
	} pdr_hit_kind_e;
endpackage

// [hw/pdr_decode.sv]
// Purpose: Decodes a bus address into a port slot and a register kind.
// Assumes: Addresses are the full 16-bit byte addresses of the I/O area.
// Notes: Purely combinational.
`timescale 1ns/1ps
module pdr_decode (
	input wire logic [15:0] i_addr,
	output logic o_data_hit,
	output logic o_dir_hit,
	output logic [2:0] o_slot
);
	always_comb begin
		o_data_hit = 1'b1;
		o_dir_hit = 1'b0;
		o_slot = 3'h0;
		case (i_addr)
			pdr_pkg::PORT1_PIN_DATA_ADDR: o_slot = 3'h0;
			pdr_pkg::PORT2_PIN_DATA_ADDR: o_slot = 3'h1;
			pdr_pkg::PORT3_PIN_DATA_ADDR: o_slot = 3'h2;
			pdr_pkg::PORT5_PIN_DATA_ADDR: o_slot = 3'h3;
			pdr_pkg::PORT6_PIN_DATA_ADDR: o_slot = 3'h4;
			pdr_pkg::PORT7_PIN_DATA_ADDR: o_slot = 3'h5;
			pdr_pkg::PORT8_PIN_DATA_ADDR: o_slot = 3'h6;
			pdr_pkg::PORT9_PIN_DATA_ADDR: o_slot = 3'h7;
			default: begin
				o_data_hit = 1'b0;
				o_dir_hit = 1'b1;
				case (i_addr)
					pdr_pkg::PORT1_DIRECTION_ADDR: o_slot = 3'h0;
					pdr_pkg::PORT2_DIRECTION_ADDR: o_slot = 3'h1;
					pdr_pkg::PORT3_DIRECTION_ADDR: o_slot = 3'h2;
					pdr_pkg::PORT5_DIRECTION_ADDR: o_slot = 3'h3;
					pdr_pkg::PORT6_DIRECTION_ADDR: o_slot = 3'h4;
					pdr_pkg::PORT7_DIRECTION_ADDR: o_slot = 3'h5;
					pdr_pkg::PORT8_DIRECTION_ADDR: o_slot = 3'h6;
					pdr_pkg::PORT9_DIRECTION_ADDR: o_slot = 3'h7;
					default: o_dir_hit = 1'b0;
				endcase
			end
		endcase
	end
endmodule

// [hw/pdr_port_bank.sv]
// Purpose: Holds the data latches and direction bits of all ports.
// Assumes: At most one write per cycle, selected by slot.
// Notes: Direction bits are never read back over the bus.
`timescale 1ns/1ps
module pdr_port_bank #(
	parameter int unsigned PORTS = pdr_pkg::PORT_COUNT
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_data_we,
	input wire logic i_dir_we,
	input wire logic [2:0] i_slot,
	input wire logic [7:0] i_wdata,
	output logic [PORTS*8-1:0] o_data,
	output logic [PORTS*8-1:0] o_dir
);
	logic [PORTS*8-1:0] data_q;
	logic [PORTS*8-1:0] dir_q;
	logic [PORTS*8-1:0] next_data_q;
	logic [PORTS*8-1:0] next_dir_q;

	always_comb begin
		next_data_q = data_q;
		next_dir_q = dir_q;
		// All eight latch bits take the byte, inputs too.
		if (i_data_we) begin
			next_data_q[i_slot*8 +: 8] = i_wdata;
		end
		if (i_dir_we) begin
			next_dir_q[i_slot*8 +: 8] = i_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_q <= {PORTS{pdr_pkg::DATA_RESET}};
			dir_q <= {PORTS{pdr_pkg::DIRECTION_RESET}};
		end else begin
			data_q <= next_data_q;
			dir_q <= next_dir_q;
		end
	end

	assign o_data = data_q;
	assign o_dir = dir_q;
endmodule

// [hw/pdr_port_regs.sv]
// Purpose: Port data and direction registers with pin drive for eight byte ports.
// Assumes: CPU byte access with address, read and write strobes; pins synchronous.
// Notes: Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/1ps
module pdr_port_regs #(
	parameter int unsigned PORTS = pdr_pkg::PORT_COUNT
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	input wire logic [PORTS*8-1:0] i_pin,
	output logic [PORTS*8-1:0] o_pin,
	output logic [PORTS*8-1:0] o_pin_oe_n
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// Decode and storage
	// ------------------------------------------------------------
	logic data_hit;
	logic dir_hit;
	logic [2:0] slot;
	logic [PORTS*8-1:0] data_q;
	logic [PORTS*8-1:0] dir_q;

	pdr_decode u_decode (
		.i_addr(i_addr),
		.o_data_hit(data_hit),
		.o_dir_hit(dir_hit),
		.o_slot(slot)
	);

	pdr_port_bank #(
		.PORTS(PORTS)
	) u_bank (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_n),
		.i_data_we(i_wr && data_hit),
		.i_dir_we(i_wr && dir_hit),
		.i_slot(slot),
		.i_wdata(i_wdata),
		.o_data(data_q),
		.o_dir(dir_q)
	);

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Output enable is low while driving; a zero direction bit releases the pin.
	assign o_pin_oe_n = ~dir_q;
	assign o_pin = data_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// A read-modify-write on a data byte copies input levels into the latch,
	// which is why software should keep its own copies.
	// One byte lane of a packed port vector; used by the read path and the checks.
	function automatic logic [7:0] slot_byte(input logic [PORTS*8-1:0] v, input logic [2:0] s);
		slot_byte = v[s*pdr_pkg::PORT_WIDTH +: 8];
	endfunction

	function automatic logic [7:0] mix_port(input logic [7:0] pin, input logic [7:0] lat,
			input logic [7:0] dir);
		mix_port = (dir & lat) | (~dir & pin);
	endfunction

	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] next_rdata;
	logic next_rvalid;

	always_comb begin
		next_rvalid = i_rd;
		next_rdata = rdata;
		if (i_rd) begin
			if (data_hit) begin
				next_rdata = mix_port(slot_byte(i_pin, slot), slot_byte(data_q, slot),
					slot_byte(dir_q, slot));
			end else if (dir_hit) begin
				next_rdata = pdr_pkg::DIRECTION_READ_VALUE;
			end else begin
				next_rdata = pdr_pkg::UNMAPPED_READ_VALUE;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= pdr_pkg::DATA_RESET;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	assign o_rdata = rdata;
	assign o_rvalid = rvalid;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Properties look at the strobes as decoded and at the outputs one edge
	// later, which is when the bank and the read register have taken them.
	sequence dir_read_s;
		i_rd && dir_hit;
	endsequence

	sequence unmapped_read_s;
		i_rd && !data_hit && !dir_hit;
	endsequence

	sequence dir_write_s;
		i_wr && dir_hit;
	endsequence

	sequence data_write_s;
		i_wr && data_hit;
	endsequence

	sequence no_read_s;
		!i_rd;
	endsequence

	// A registered copy of the last accepted write lets the checks compare
	// the outputs with what was asked for without deep history chains.
	logic chk_wr;
	logic chk_dir;
	logic [2:0] chk_slot;
	logic [7:0] chk_byte;
	logic next_chk_wr;
	logic next_chk_dir;
	logic [2:0] next_chk_slot;
	logic [7:0] next_chk_byte;

	always_comb begin
		next_chk_wr = i_wr && (data_hit || dir_hit);
		next_chk_dir = dir_hit;
		next_chk_slot = slot;
		next_chk_byte = i_wdata;
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_wr <= 1'b0;
			chk_dir <= 1'b0;
			chk_slot <= 3'h0;
			chk_byte <= pdr_pkg::DATA_RESET;
		end else begin
			chk_wr <= next_chk_wr;
			chk_dir <= next_chk_dir;
			chk_slot <= next_chk_slot;
			chk_byte <= next_chk_byte;
		end
	end

	AST_DIR_READ_ONES: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		dir_read_s |=> (o_rvalid && o_rdata == pdr_pkg::DIRECTION_READ_VALUE))
		else $error("direction read not ones");

	// Every zero written to a direction bit must leave that pin released.
	AST_INPUT_RELEASED: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		dir_write_s |=> ((~o_pin_oe_n[$past(slot)*8 +: 8] & ~$past(i_wdata)) == 8'h00))
		else $error("input pin still driven");

	// Every one written to a direction bit must enable that pin's driver.
	AST_OUTPUT_ENABLED: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		dir_write_s |=> ((o_pin_oe_n[$past(slot)*8 +: 8] & $past(i_wdata)) == 8'h00))
		else $error("output pin not enabled");

	AST_LAST_DIR_LANDS: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(chk_wr && chk_dir) |-> slot_byte(o_pin_oe_n, chk_slot) == ~chk_byte)
		else $error("last direction write not on enables");

	AST_LAST_DATA_LANDS: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(chk_wr && !chk_dir) |-> slot_byte(o_pin, chk_slot) == chk_byte)
		else $error("last data write not on pins");

	AST_DIR_WRITE_OE: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(i_wr && dir_hit) |=> (o_pin_oe_n[$past(slot)*8 +: 8] == ~$past(i_wdata)))
		else $error("direction write not applied to output enables");

	AST_OUT_DRIVEN: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(i_wr && data_hit) |=> (o_pin[$past(slot)*8 +: 8] == $past(i_wdata)))
		else $error("data write not on pins");

	AST_DATA_READ_MIX: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(i_rd && data_hit && !i_wr) |=> o_rdata == (($past(dir_q[slot*8 +: 8]) &
		$past(data_q[slot*8 +: 8])) | (~$past(dir_q[slot*8 +: 8]) & $past(i_pin[slot*8 +: 8]))))
		else $error("data read mix wrong");

	AST_DATA_READ_ADDR: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(i_rd && data_hit && dir_q[slot*8 +: 8] == 8'h00) |=> o_rdata == $past(i_pin[slot*8 +: 8]))
		else $error("data address does not read pins");

	AST_LATCH_ALL_BITS: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(i_wr && data_hit) |=> data_q[$past(slot)*8 +: 8] == $past(i_wdata) ##1
		(data_q[$past(slot, 2)*8 +: 8] == $past(i_wdata, 2) || $past(i_wr)))
		else $error("latch did not take full byte");

	AST_RVALID_PULSE: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		no_read_s |=> !o_rvalid) else $error("read valid without read");

	AST_RVALID_AFTER_READ: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		i_rd |=> o_rvalid) else $error("read not answered");

	// Read data must stand untouched until the next read.
	AST_RDATA_HOLDS: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		no_read_s |=> $stable(o_rdata)) else $error("read data changed without read");

	AST_UNMAPPED_READ: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		unmapped_read_s |=> o_rdata == pdr_pkg::UNMAPPED_READ_VALUE)
		else $error("unmapped read value wrong");

	// Pins and enables only move on a write to their own register kind.
	AST_DIR_HOLDS: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		!(i_wr && dir_hit) |=> $stable(o_pin_oe_n))
		else $error("enables changed without direction write");

	AST_DATA_HOLDS: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		!(i_wr && data_hit) |=> $stable(o_pin)) else $error("pins changed without data write");

	// While reset is held every pin must be an undriven input.
	AST_RESET_STATE: assert property (@(posedge i_core_clk)
		!rst_n |-> (o_pin_oe_n == '1 && o_pin == '0 && !o_rvalid))
		else $error("reset state wrong");
endmodule

// [bench/pdr_pin_model.sv]
// Purpose: Board-side model of the eight byte ports' pins.
// Assumes: Each released line is held by the board at a level the bench picks.
// Notes: A driven line shows the latch bit, a released line the board level.
`timescale 1ns/1ps
module pdr_pin_model (
	input wire logic [63:0] i_pin_out,
	input wire logic [63:0] i_pin_oe_n,
	input wire logic [63:0] i_board,
	output logic [63:0] o_level
);
	// The board level replaces a released line at once, so no stale drive lingers.
	assign o_level = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_board);
endmodule

// [bench/port_data_direction_regs_bench.sv]
// Purpose: Self-checking bench for the port data and direction registers.
// Assumes: Inputs change at the falling edge; read data is checked a cycle later.
// Notes: Shadow copies of every latch and direction byte give the expectations.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module port_data_direction_regs_bench;
	logic i_core_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic i_rd = 1'b0;
	logic i_wr = 1'b0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_rvalid;
	logic [63:0] i_pin;
	logic [63:0] o_pin;
	logic [63:0] o_pin_oe_n;
	logic [63:0] board = 64'h0;
	logic [7:0] lat [8];
	logic [7:0] dir [8];
	logic [7:0] d;
	int err_total = 0;
	int checks_done = 0;
	int seed = 62945;
	int cycles = 0;
	int s;
	pdr_port_regs #(.PORTS(8)) dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n));
	pdr_pin_model pins (.i_pin_out(o_pin), .i_pin_oe_n(o_pin_oe_n), .i_board(board),
		.o_level(i_pin));
	initial forever #5 i_core_clk = ~i_core_clk;
	// -----------------------------------------------
	// Helpers
	// -----------------------------------------------
	function automatic logic [15:0] reg_addr(input int slot, input bit is_dir);
		return 16'hFFD4 + 16'(slot) + ((slot > 2) ? 16'h0001 : 16'h0000)
			+ (is_dir ? 16'h0010 : 16'h0000);
	endfunction
	function automatic logic [7:0] exp_read(input int slot);
		return (dir[slot] & lat[slot]) | (~dir[slot] & board[slot*8 +: 8]);
	endfunction
	task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge i_core_clk);
		i_addr = a;
		i_wdata = v;
		i_wr = 1'b1;
		@(negedge i_core_clk);
		i_wr = 1'b0;
	endtask
	task automatic bus_rd(input logic [15:0] a, output logic [7:0] v);
		@(negedge i_core_clk);
		i_addr = a;
		i_rd = 1'b1;
		@(negedge i_core_clk);
		i_rd = 1'b0;
		`CHK(o_rvalid, 1'b1)
		v = o_rdata;
	endtask
	// Software side keeps whole-byte shadows instead of read-modify-write.
	task automatic set_port(input int slot, input logic [7:0] dv, input logic [7:0] rv);
		lat[slot] = dv;
		dir[slot] = rv;
		bus_wr(reg_addr(slot, 1'b0), dv);
		bus_wr(reg_addr(slot, 1'b1), rv);
		`CHK(o_pin[slot*8 +: 8], dv)
		`CHK(o_pin_oe_n[slot*8 +: 8], ~rv)
	endtask
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// The ceiling leaves ample margin over the roughly 1,000 cycles of the run.
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	// -----------------------------------------------
	// Main sequence
	// -----------------------------------------------
	initial begin
		repeat (2) @(negedge i_core_clk);
		i_rstn = 1'b1;
		repeat (3) @(negedge i_core_clk);
		`CHK(o_pin_oe_n, {64{1'b1}})
		for (s = 0; s < 8; s++) begin
			set_port(s, 8'h00, 8'h00);
		end
		set_port(2, 8'h80, 8'h3F);
		board[23:16] = 8'h40;
		bus_rd(reg_addr(2, 1'b0), d);
		`CHK(d, 8'h40)
		bus_rd(reg_addr(2, 1'b1), d);
		`CHK(d, 8'hFF)
		set_port(2, 8'h80, 8'h3E);
		`CHK(o_pin_oe_n[23:16], 8'hC1)
		bus_rd(16'hFFD7, d);
		`CHK(d, 8'hFF)
		for (int n = 0; n < 120; n++) begin
			s = {$random(seed)} % 8;
			set_port(s, 8'($random(seed)), 8'($random(seed)));
			board = {$random(seed), $random(seed)};
			bus_rd(reg_addr(s, 1'b0), d);
			`CHK(d, exp_read(s))
			bus_rd(reg_addr(s, 1'b1), d);
			`CHK(d, 8'hFF)
		end
		// A reset in mid-run must drop every latch and release every pin.
		@(negedge i_core_clk);
		i_rstn = 1'b0;
		repeat (2) @(negedge i_core_clk);
		`CHK(o_pin_oe_n, {64{1'b1}})
		`CHK(o_pin, 64'h0)
		`CHK(o_rvalid, 1'b0)
		`CHK(o_rdata, 8'h00)
		i_rstn = 1'b1;
		repeat (3) @(negedge i_core_clk);
		for (s = 0; s < 8; s++) begin
			lat[s] = 8'h00;
			dir[s] = 8'h00;
		end
		board = {$random(seed), $random(seed)};
		bus_rd(reg_addr(3, 1'b0), d);
		`CHK(d, exp_read(3))
		print_verdict();
	end
endmodule
